/* shared/regctl_pkg.sv */
/*
  Constants and types shared by the regulator state control and its timers.
  Assumes a single 250 MHz core clock; every time is derived from CLK_PERIOD_NS.
*/
package regctl_pkg;
  // Core clock.
  localparam int unsigned CLK_PERIOD_NS = 4;

  // Clock-held-low reset time, the wait for a fault to clear and the housekeeping settle time, in their own units.
  localparam int unsigned SCL_LOW_RESET_MS = 100;
  localparam int unsigned SCL_LOW_RESET_CYC = (SCL_LOW_RESET_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FAULT_WAIT_MS = 20;
  localparam int unsigned FAULT_WAIT_CYC = (FAULT_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HK_SETTLE_US = 10;
  localparam int unsigned HK_SETTLE_CYC = (HK_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Serial bus slave address; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR = 7'h2a;

  // Register offsets.
  localparam logic [7:0] CTRL_OFS = 8'h01;
  localparam logic [7:0] STATUS_OFS = 8'h02;
  localparam logic [7:0] FAULT_OFS = 8'h03;
  localparam logic [7:0] SWRESET_OFS = 8'h04;
  localparam logic [7:0] SWRESET_CODE = 8'ha5;

  // Field positions.
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_FFM_BIT = 1;
  localparam int unsigned STAT_READY_BIT = 0;
  localparam int unsigned STAT_UVLO_BIT = 1;
  localparam int unsigned STAT_OT_BIT = 2;
  localparam int unsigned FLT_UVLO_BIT = 0;
  localparam int unsigned FLT_OT_BIT = 1;

  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FAULT_RST = 8'h00;

  // Synchroniser bit positions.
  localparam int unsigned SYNC_W = 6;
  localparam int unsigned SY_SCL = 0;
  localparam int unsigned SY_SDA = 1;
  localparam int unsigned SY_POR = 2;
  localparam int unsigned SY_RISE = 3;
  localparam int unsigned SY_FALL = 4;
  localparam int unsigned SY_OT = 5;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RESET = 2'b01,
    ST_IDLE = 2'b10,
    ST_ACTIVE = 2'b11
  } dev_state_t;

  typedef enum logic [3:0] {
    I_IDLE = 4'b0000,
    I_ADDR = 4'b0001,
    I_ACKA = 4'b0010,
    I_PTR = 4'b0011,
    I_ACKP = 4'b0100,
    I_WDATA = 4'b0101,
    I_ACKW = 4'b0110,
    I_RDATA = 4'b0111,
    I_RACK = 4'b1000
  } bus_state_t;
endpackage

/* shared/tmr_if.sv */
/*
  Handshake between the state control and one of its event timers.
  Assumes both ends sit on the same core clock.
*/
`timescale 1ns/1ps
interface tmr_if;
  logic restart;
  logic run;
  logic expired;
  modport owner (output restart, output run, input expired);
  modport timer (input restart, input run, output expired);
endinterface

/* rtl/event_timer.sv */
/*
  Restartable cycle counter that flags once LIMIT running cycles have passed.
  Assumes restart and run come from logic on the same clock.
*/
`timescale 1ns/1ps
module event_timer #(
  parameter int unsigned LIMIT = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Control from the owner.
  tmr_if.timer tmr
);
  logic [31:0] count_reg;
  logic expired_reg;

  // Restart wins over counting so that a new wait always begins from zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= 32'h0;
      expired_reg <= 1'b0;
    end else if (tmr.restart) begin
      count_reg <= 32'h0;
      expired_reg <= 1'b0;
    end else if (tmr.run && !expired_reg) begin
      count_reg <= count_reg + 32'h1;
      expired_reg <= (count_reg + 32'h1) >= LIMIT;
    end
  end

  assign tmr.expired = expired_reg;
endmodule

/* rtl/regulator_state_control.sv */
/*
  Digital state control of a step-down regulator: power-up, reset, idle and
  active states, the serial register slave, fault gating and the ready flag.
  Assumes analog comparators and the bus pins are asynchronous to clk and an
  open-drain data pin resolved outside from sda_oe.
*/
`timescale 1ns/1ps
module regulator_state_control #(
  parameter int unsigned SCL_LOW_CYC = regctl_pkg::SCL_LOW_RESET_CYC,
  parameter int unsigned FAULT_WAIT_CYC = regctl_pkg::FAULT_WAIT_CYC
) (
  // Clock and power-on reset.
  input wire logic clk,
  input wire logic arst_n,
  // Serial bus pins.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Analog comparator levels.
  input wire logic supply_above_por,
  input wire logic supply_above_uvlo_rise,
  input wire logic supply_above_uvlo_fall,
  input wire logic overtemperature_condition,
  // Controls to the power stage.
  output logic buck_enable,
  output logic forced_fixed_frequency_mode,
  output logic housekeeping_on,
  output logic ready
);
  regctl_pkg::dev_state_t state_reg;
  regctl_pkg::bus_state_t bus_reg;
  logic [regctl_pkg::SYNC_W-1:0] sync1_reg;
  logic [regctl_pkg::SYNC_W-1:0] sync2_reg;
  logic scl_d_reg, sda_d_reg;
  logic wait_scl_reg, hold_low_reg, hk_on_reg, fault_wait_reg, ready_reg;
  logic [7:0] ctrl_reg, fault_reg, shift_reg, ptr_reg, wr_data_reg;
  logic [3:0] bit_cnt_reg;
  logic rw_reg, sda_oe_reg, wr_stb_reg, rd_clr_reg;
  logic scl_s, sda_s, por_ok, rise_ok, fall_ok, ot_s;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic running, uvlo_now, ot_now, fault_now, sw_reset_hit, leave_reset, fault_wait_start;
  logic [7:0] status_byte, fault_next, rd_ptr, rd_byte;

  tmr_if scl_t ();
  tmr_if hk_t ();
  tmr_if flt_t ();

  event_timer #(.LIMIT(SCL_LOW_CYC)) u_scl_timer (.clk(clk), .arst_n(arst_n), .tmr(scl_t));
  event_timer #(.LIMIT(regctl_pkg::HK_SETTLE_CYC)) u_hk_timer (.clk(clk), .arst_n(arst_n), .tmr(hk_t));
  event_timer #(.LIMIT(FAULT_WAIT_CYC)) u_flt_timer (.clk(clk), .arst_n(arst_n), .tmr(flt_t));

  // Two flip-flops on every asynchronous input; the third copy only feeds edge detection.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      scl_d_reg <= 1'b0;
      sda_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {overtemperature_condition, supply_above_uvlo_fall, supply_above_uvlo_rise,
                    supply_above_por, sda_in, scl_in};
      sync2_reg <= sync1_reg;
      scl_d_reg <= sync2_reg[regctl_pkg::SY_SCL];
      sda_d_reg <= sync2_reg[regctl_pkg::SY_SDA];
    end
  end

  assign scl_s = sync2_reg[regctl_pkg::SY_SCL];
  assign sda_s = sync2_reg[regctl_pkg::SY_SDA];
  assign por_ok = sync2_reg[regctl_pkg::SY_POR];
  assign rise_ok = sync2_reg[regctl_pkg::SY_RISE];
  assign fall_ok = sync2_reg[regctl_pkg::SY_FALL];
  assign ot_s = sync2_reg[regctl_pkg::SY_OT];
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign bus_start = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign bus_stop = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // Fault detection: idle checks the rising threshold, active the falling one.
  assign running = (state_reg == regctl_pkg::ST_IDLE) || (state_reg == regctl_pkg::ST_ACTIVE);
  assign uvlo_now = ((state_reg == regctl_pkg::ST_IDLE) && !rise_ok) ||
                    ((state_reg == regctl_pkg::ST_ACTIVE) && !fall_ok);
  assign ot_now = running && ot_s;
  assign fault_now = uvlo_now || ot_now;
  assign sw_reset_hit = wr_stb_reg && (ptr_reg == regctl_pkg::SWRESET_OFS) &&
                        (wr_data_reg == regctl_pkg::SWRESET_CODE);
  assign leave_reset = (state_reg == regctl_pkg::ST_RESET) && por_ok && (!wait_scl_reg || scl_s);
  assign fault_wait_start = (leave_reset && (!rise_ok || ot_s)) ||
                            ((state_reg == regctl_pkg::ST_ACTIVE) && fault_now);

  // Timer hookup: the low-time count restarts whenever the clock line is high.
  assign scl_t.restart = scl_s;
  assign scl_t.run = running;
  assign hk_t.restart = !hk_on_reg;
  assign hk_t.run = hk_on_reg;
  assign flt_t.restart = fault_wait_start;
  assign flt_t.run = fault_wait_reg;

  // Device state sequence; losing the supply overrides everything else.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= regctl_pkg::ST_OFF;
      wait_scl_reg <= 1'b1;
      hold_low_reg <= 1'b0;
    end else if (!por_ok) begin
      state_reg <= regctl_pkg::ST_OFF;
      wait_scl_reg <= 1'b1;
      hold_low_reg <= 1'b0;
    end else begin
      case (state_reg)
        regctl_pkg::ST_OFF: begin
          state_reg <= regctl_pkg::ST_RESET;
          wait_scl_reg <= 1'b1;
        end
        regctl_pkg::ST_RESET: begin
          if (leave_reset) begin
            state_reg <= regctl_pkg::ST_IDLE;
            hold_low_reg <= 1'b0;
          end
        end
        regctl_pkg::ST_IDLE, regctl_pkg::ST_ACTIVE: begin
          if (sw_reset_hit) begin
            state_reg <= regctl_pkg::ST_RESET;
            wait_scl_reg <= 1'b0;
          end else if (scl_t.expired) begin
            state_reg <= regctl_pkg::ST_RESET;
            wait_scl_reg <= 1'b1;
            hold_low_reg <= 1'b1;
          end else if (state_reg == regctl_pkg::ST_ACTIVE) begin
            if (fault_now) begin
              state_reg <= regctl_pkg::ST_IDLE;
            end
          end else if (ctrl_reg[regctl_pkg::CTRL_ENABLE_BIT] && !fault_now) begin
            state_reg <= regctl_pkg::ST_ACTIVE;
          end
        end
        default: state_reg <= regctl_pkg::ST_OFF;
      endcase
    end
  end

  // Housekeeping is shut down through a clock-held-low reset and comes back when it ends.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hk_on_reg <= 1'b0;
    end else begin
      hk_on_reg <= (state_reg != regctl_pkg::ST_OFF) && !((state_reg == regctl_pkg::ST_RESET) && hold_low_reg);
    end
  end

  // Fault wait window and the ready flag that it holds off.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_wait_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      if (fault_wait_start) begin
        fault_wait_reg <= 1'b1;
      end else if (flt_t.expired || !running) begin
        fault_wait_reg <= 1'b0;
      end
      ready_reg <= hk_t.expired && running && !fault_now && !fault_wait_reg;
    end
  end

  // Sticky faults: a read clears them, but an event in the same cycle survives.
  always_comb begin
    fault_next = rd_clr_reg ? regctl_pkg::FAULT_RST : fault_reg;
    fault_next[regctl_pkg::FLT_UVLO_BIT] = fault_next[regctl_pkg::FLT_UVLO_BIT] || uvlo_now;
    fault_next[regctl_pkg::FLT_OT_BIT] = fault_next[regctl_pkg::FLT_OT_BIT] || ot_now;
  end

  // Live status: bits follow the condition and drop as soon as it ends.
  always_comb begin
    status_byte = 8'h00;
    status_byte[regctl_pkg::STAT_READY_BIT] = ready_reg;
    status_byte[regctl_pkg::STAT_UVLO_BIT] = uvlo_now;
    status_byte[regctl_pkg::STAT_OT_BIT] = ot_now;
  end

  // Software registers; both return to defaults whenever the device is not running.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= regctl_pkg::CTRL_RST;
      fault_reg <= regctl_pkg::FAULT_RST;
    end else if (!running) begin
      ctrl_reg <= regctl_pkg::CTRL_RST;
      fault_reg <= regctl_pkg::FAULT_RST;
    end else begin
      fault_reg <= fault_next;
      if ((state_reg == regctl_pkg::ST_ACTIVE) && fault_now) begin
        ctrl_reg[regctl_pkg::CTRL_ENABLE_BIT] <= 1'b0;
      end else if (wr_stb_reg && (ptr_reg == regctl_pkg::CTRL_OFS)) begin
        ctrl_reg[regctl_pkg::CTRL_FFM_BIT] <= wr_data_reg[regctl_pkg::CTRL_FFM_BIT];
        ctrl_reg[regctl_pkg::CTRL_ENABLE_BIT] <= wr_data_reg[regctl_pkg::CTRL_ENABLE_BIT] && !fault_now;
      end
    end
  end

  // Read multiplexer shared by the first and the following bytes of a read.
  function automatic logic [7:0] reg_read(input logic [7:0] p, input logic [7:0] c,
                                          input logic [7:0] s, input logic [7:0] f);
    case (p)
      regctl_pkg::CTRL_OFS: reg_read = c;
      regctl_pkg::STATUS_OFS: reg_read = s;
      regctl_pkg::FAULT_OFS: reg_read = f;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // Byte to load next: the pointer itself after the address, the following one after a master ack.
  assign rd_ptr = (bus_reg == regctl_pkg::I_RACK) ? ptr_reg + 8'h01 : ptr_reg;
  assign rd_byte = reg_read(rd_ptr, ctrl_reg, status_byte, fault_reg);

  // Serial slave: samples on clock rise, drives data after clock fall; silent outside idle and active.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_reg <= regctl_pkg::I_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
      rd_clr_reg <= 1'b0;
    end else begin
      wr_stb_reg <= 1'b0;
      rd_clr_reg <= 1'b0;
      if (bus_stop || !running) begin
        bus_reg <= regctl_pkg::I_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (bus_start) begin
        bus_reg <= regctl_pkg::I_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_reg <= 1'b0;
      end else if (scl_rise) begin
        case (bus_reg)
          regctl_pkg::I_ADDR, regctl_pkg::I_PTR, regctl_pkg::I_WDATA: begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          regctl_pkg::I_RACK: begin
            if (sda_s) begin
              bus_reg <= regctl_pkg::I_IDLE; // Master declined further bytes.
            end
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (bus_reg)
          regctl_pkg::I_ADDR: begin
            if (bit_cnt_reg == 4'h8) begin
              if (shift_reg[7:1] == regctl_pkg::DEV_ADDR) begin
                rw_reg <= shift_reg[0];
                sda_oe_reg <= 1'b1;
                bus_reg <= regctl_pkg::I_ACKA;
              end else begin
                bus_reg <= regctl_pkg::I_IDLE;
              end
            end
          end
          regctl_pkg::I_PTR: begin
            if (bit_cnt_reg == 4'h8) begin
              ptr_reg <= shift_reg;
              sda_oe_reg <= 1'b1;
              bus_reg <= regctl_pkg::I_ACKP;
            end
          end
          regctl_pkg::I_WDATA: begin
            if (bit_cnt_reg == 4'h8) begin
              wr_data_reg <= shift_reg;
              wr_stb_reg <= 1'b1;
              sda_oe_reg <= 1'b1;
              bus_reg <= regctl_pkg::I_ACKW;
            end
          end
          regctl_pkg::I_ACKA, regctl_pkg::I_RACK: begin
            bit_cnt_reg <= 4'h0;
            if (bus_reg == regctl_pkg::I_ACKA && !rw_reg) begin
              sda_oe_reg <= 1'b0;
              bus_reg <= regctl_pkg::I_PTR;
            end else begin
              shift_reg <= rd_byte;
              sda_oe_reg <= !rd_byte[7];
              rd_clr_reg <= rd_ptr == regctl_pkg::FAULT_OFS;
              if (bus_reg == regctl_pkg::I_RACK) begin
                ptr_reg <= ptr_reg + 8'h01;
              end
              bus_reg <= regctl_pkg::I_RDATA;
            end
          end
          regctl_pkg::I_ACKP, regctl_pkg::I_ACKW: begin
            sda_oe_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            if (bus_reg == regctl_pkg::I_ACKW) begin
              ptr_reg <= ptr_reg + 8'h01;
            end
            bus_reg <= regctl_pkg::I_WDATA;
          end
          regctl_pkg::I_RDATA: begin
            if (bit_cnt_reg == 4'h7) begin
              sda_oe_reg <= 1'b0;
              bus_reg <= regctl_pkg::I_RACK;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe_reg <= !shift_reg[6];
            end
          end
          default: bus_reg <= regctl_pkg::I_IDLE;
        endcase
      end
    end
  end

  // Outputs; the host is expected to allow time after a clock-low reset before the next access.
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_reg;
  assign buck_enable = state_reg == regctl_pkg::ST_ACTIVE;
  assign forced_fixed_frequency_mode = ctrl_reg[regctl_pkg::CTRL_FFM_BIT];
  assign housekeeping_on = hk_on_reg;
  assign ready = ready_reg;
endmodule

/* tb/regulator_state_control_props.sv */
/*
  Concurrent checks on the ports of the regulator state control.
  Assumes one clock domain and is attached to every instance by the bind below.
*/
`timescale 1ns/1ps
module regulator_state_control_props #(
  parameter int unsigned SCL_LOW_CYC = 200,
  parameter int unsigned FAULT_WAIT_CYC = 100
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Bus pins.
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Comparator levels.
  input wire logic supply_above_por,
  input wire logic supply_above_uvlo_rise,
  input wire logic supply_above_uvlo_fall,
  input wire logic overtemperature_condition,
  // Power stage controls.
  input wire logic buck_enable,
  input wire logic forced_fixed_frequency_mode,
  input wire logic housekeeping_on,
  input wire logic ready
);
  logic [12:0] hk_cnt;
  logic [15:0] low_cnt;

  // Cycles since housekeeping came on; it saturates so it never wraps below the settle time.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hk_cnt <= 13'h0000;
    end else if (!housekeeping_on) begin
      hk_cnt <= 13'h0000;
    end else if (hk_cnt != 13'h1fff) begin
      hk_cnt <= hk_cnt + 13'h0001;
    end
  end

  // Cycles the bus clock pin has stayed low.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt <= 16'h0000;
    end else if (scl_in) begin
      low_cnt <= 16'h0000;
    end else if (low_cnt != 16'hffff) begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Five cycles cover the two synchroniser stages, the state update and the registered outputs.
  sequence por_lost;
    !supply_above_por [*5];
  endsequence
  sequence ot_held;
    overtemperature_condition [*5];
  endsequence

  por_off_a: assert property (por_lost |-> !buck_enable && !housekeeping_on && !ready)
    else $error("outputs kept after supply loss");
  hk_enable_a: assert property (buck_enable |-> housekeeping_on)
    else $error("converter on without housekeeping");
  hk_ready_a: assert property (ready |-> housekeeping_on)
    else $error("ready without housekeeping");
  settle_time_a: assert property (ready |-> hk_cnt >= regctl_pkg::HK_SETTLE_CYC)
    else $error("ready before housekeeping settled");
  ot_ready_a: assert property (ot_held |-> !ready)
    else $error("ready during overtemperature");
  ot_enable_a: assert property (ot_held |-> !buck_enable)
    else $error("converter on during overtemperature");
  uvlo_enable_a: assert property (!supply_above_uvlo_fall [*5] |-> !buck_enable)
    else $error("converter on below falling threshold");
  uvlo_ready_a: assert property ((!supply_above_uvlo_rise && !buck_enable) [*5] |-> !ready)
    else $error("ready below rising threshold while stopped");
  scl_reset_a: assert property (low_cnt > SCL_LOW_CYC + 8 |-> !buck_enable && !ready)
    else $error("no reset after long clock low");
  bus_quiet_a: assert property (sda_oe |-> housekeeping_on)
    else $error("data pin driven while powered down");
endmodule

bind regulator_state_control regulator_state_control_props #(
  .SCL_LOW_CYC(SCL_LOW_CYC),
  .FAULT_WAIT_CYC(FAULT_WAIT_CYC)
) chk (.clk(clk), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .supply_above_por(supply_above_por), .supply_above_uvlo_rise(supply_above_uvlo_rise),
  .supply_above_uvlo_fall(supply_above_uvlo_fall), .overtemperature_condition(overtemperature_condition),
  .buck_enable(buck_enable), .forced_fixed_frequency_mode(forced_fixed_frequency_mode),
  .housekeeping_on(housekeeping_on), .ready(ready));

/* tb/bus_host_model.sv */
/*
  Behavioural two-wire bus host that talks to the regulator's register slave.
  Assumes the data line is resolved outside with a pull-up; a phase is four core clocks.
*/
`timescale 1ns/1ps
module bus_host_model (
  // Clock.
  input wire logic clk,
  // Bus lines.
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  // The bus idles released, so both lines sit high between frames.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Data moves mid-low so it never changes beside a clock edge on the pins.
  task automatic xbit(input logic b, output logic r);
    tick(2);
    sda_drv <= b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    r = sda_line;
    scl <= 1'b0;
  endtask

  task automatic start();
    tick(2);
    sda_drv <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask

  task automatic stop();
    tick(2);
    sda_drv <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
  endtask

  task automatic xbyte(input logic [7:0] d, input logic m_ack, output logic [7:0] q, output logic s_ack);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(m_ack, s_ack);
  endtask

  task automatic write(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0;
    logic a1;
    logic a2;
    start();
    xbyte({regctl_pkg::DEV_ADDR, 1'b0}, 1'b1, q, a0);
    xbyte(ptr, 1'b1, q, a1);
    xbyte(d, 1'b1, q, a2);
    stop();
    ok = !a0 && !a1 && !a2;
  endtask

  // The last byte is refused by the host so the slave lets go of the line.
  task automatic read(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    start();
    xbyte({regctl_pkg::DEV_ADDR, 1'b0}, 1'b1, q, a0);
    xbyte(ptr, 1'b1, q, a1);
    start();
    xbyte({regctl_pkg::DEV_ADDR, 1'b1}, 1'b1, q, a2);
    xbyte(8'hff, 1'b1, d, a3);
    stop();
    ok = !a0 && !a1 && !a2;
  endtask

  task automatic hold_low(input int n);
    scl <= 1'b0;
    tick(n);
    scl <= 1'b1;
    tick(8);
  endtask

  // After a long clock-low reset the host lets the slave wake before talking.
  task automatic release_bus();
    scl <= 1'b1;
    tick(5000);
  endtask
endmodule

/* tb/regulator_state_control_test.sv */
/*
  Self-checking bench for the regulator state control with a bus host model.
  Assumes shortened clock-low and fault-wait counts set at the instance below.
*/
`timescale 1ns/1ps
module regulator_state_control_test;
  localparam int unsigned SCL_LOW = 200;
  localparam int unsigned FWAIT = 100;
  localparam logic [7:0] CTRL = regctl_pkg::CTRL_OFS;
  localparam logic [7:0] STAT = regctl_pkg::STATUS_OFS;
  localparam logic [7:0] FLT = regctl_pkg::FAULT_OFS;
  logic clk;
  logic arst_n;
  // Supply level: 0 below power-on, 1 below falling, 2 below rising, 3 above rising.
  logic [1:0] supply_lvl;
  wire logic por = supply_lvl != 2'h0;
  wire logic uv_fall = supply_lvl > 2'h1;
  wire logic uv_rise = supply_lvl == 2'h3;
  logic ot;
  logic scl;
  logic host_sda;
  logic sda_out;
  logic sda_oe;
  logic buck;
  logic ffm;
  logic hk;
  logic ready;
  logic ok;
  logic [7:0] d;
  int n_mismatch;
  int n_checks;
  int cyc;
  // Open-drain data line with a pull-up: low if either party pulls it.
  wire logic sda_line = host_sda & (sda_oe ? sda_out : 1'b1);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  bus_host_model host (.clk(clk), .scl(scl), .sda_drv(host_sda), .sda_line(sda_line));

  regulator_state_control #(.SCL_LOW_CYC(SCL_LOW), .FAULT_WAIT_CYC(FWAIT)) DUT (
    .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .supply_above_por(por), .supply_above_uvlo_rise(uv_rise), .supply_above_uvlo_fall(uv_fall),
    .overtemperature_condition(ot), .buck_enable(buck), .forced_fixed_frequency_mode(ffm),
    .housekeeping_on(hk), .ready(ready));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // A hang would otherwise stall the run; the tests need about 19000 cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_b(input logic got, input logic exp, input string what);
    check({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp, input string what);
    host.read(ptr, d, ok);
    check_b(ok, 1'b1, "read acknowledged");
    check(d, exp, what);
  endtask

  task automatic wr_chk(input logic [7:0] ptr, input logic [7:0] v);
    host.write(ptr, v, ok);
    check_b(ok, 1'b1, "write acknowledged");
    host.tick(4);
  endtask

  task automatic wait_ready(input logic exp, input int lim);
    for (int i = 0; i < lim && ready !== exp; i++) @(posedge clk);
    check_b(ready, exp, "ready level");
  endtask

  task automatic t_por();
    @(posedge clk);
    host.scl <= 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    host.tick(3000);
    check_b(ready, 1'b0, "ready while clock held low");
    host.scl <= 1'b1;
    wait_ready(1'b1, 3000);
    rd_chk(CTRL, regctl_pkg::CTRL_RST, "control default");
    $display("t_por done");
  endtask

  task automatic t_regs();
    wr_chk(CTRL, 8'h03);
    check_b(buck, 1'b1, "enable starts converter");
    check_b(ffm, 1'b1, "forced mode on");
    rd_chk(STAT, 8'h01, "status ready");
    host.write(STAT, 8'hff, ok);
    rd_chk(STAT, 8'h01, "status read only");
    rd_chk(8'h07, 8'h00, "unmapped read");
    wr_chk(CTRL, 8'h01);
    check_b(ffm, 1'b0, "forced mode off");
    $display("t_regs done");
  endtask

  task automatic t_swreset();
    host.write(regctl_pkg::SWRESET_OFS, 8'h5a, ok);
    check_b(buck, 1'b1, "wrong code ignored");
    host.write(regctl_pkg::SWRESET_OFS, regctl_pkg::SWRESET_CODE, ok);
    check_b(ok, 1'b0, "reset cuts data ack");
    check_b(buck, 1'b0, "soft reset stops converter");
    check_b(hk, 1'b1, "housekeeping kept");
    wait_ready(1'b1, 3000);
    rd_chk(CTRL, 8'h00, "control cleared");
    $display("t_swreset done");
  endtask

  task automatic t_scl_low();
    wr_chk(CTRL, 8'h01);
    host.hold_low(SCL_LOW - 50);
    host.hold_low(SCL_LOW - 50);
    check_b(buck, 1'b1, "short lows do not add up");
    host.scl <= 1'b0;
    host.tick(SCL_LOW + 20);
    check_b(buck, 1'b0, "long low resets");
    check_b(hk, 1'b0, "housekeeping off");
    host.tick(300);
    check_b(hk, 1'b0, "held while low");
    host.release_bus();
    wait_ready(1'b1, 3000);
    rd_chk(CTRL, 8'h00, "defaults after low reset");
    $display("t_scl_low done");
  endtask

  task automatic t_fault();
    ot <= 1'b1;
    host.tick(10);
    check_b(ready, 1'b0, "ready drops on fault");
    rd_chk(STAT, 8'h04, "live fault status");
    wr_chk(CTRL, 8'h01);
    check_b(buck, 1'b0, "enable refused");
    rd_chk(CTRL, 8'h00, "enable cleared");
    ot <= 1'b0;
    wait_ready(1'b1, FWAIT + 3000);
    rd_chk(FLT, 8'h02, "sticky fault");
    rd_chk(FLT, 8'h00, "fault cleared by read");
    check_b(buck, 1'b0, "no start without new write");
    wr_chk(CTRL, 8'h01);
    check_b(buck, 1'b1, "fresh enable starts");
    supply_lvl <= 2'h1;
    host.tick(10);
    check_b(buck, 1'b0, "undervoltage stops converter");
    supply_lvl <= 2'h3;
    host.tick(20);
    check_b(ready, 1'b0, "ready low in fault wait");
    wait_ready(1'b1, FWAIT + 100);
    rd_chk(CTRL, 8'h00, "enable cleared by undervoltage");
    $display("t_fault done");
  endtask

  task automatic t_por_drop();
    wr_chk(CTRL, 8'h01);
    supply_lvl <= 2'h0;
    host.tick(6);
    check({5'h00, buck, hk, ready}, 8'h00, "all off below power-on level");
    host.write(CTRL, 8'h01, ok);
    check_b(ok, 1'b0, "bus silent when off");
    supply_lvl <= 2'h2;
    host.tick(3500);
    check_b(ready, 1'b0, "no ready below rising level");
    rd_chk(STAT, 8'h02, "undervoltage live");
    rd_chk(FLT, 8'h01, "undervoltage fault");
    supply_lvl <= 2'h3;
    wait_ready(1'b1, FWAIT + 3000);
    $display("t_por_drop done");
  endtask

  initial begin
    arst_n = 1'b0;
    supply_lvl = 2'h3;
    ot = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    cyc = 0;
    t_por();
    t_regs();
    t_swreset();
    t_scl_low();
    t_fault();
    t_por_drop();
    wrap_up();
  end
endmodule
